//--- fsb_bound_regs.sv
// Frame-period and shutter bound registers with their activation logic,
// fixed or capped shutter selection, frame timing and firmware revision.
// Assumes the serial port logic decodes accesses into one-cycle read and
// write strobes on ref_clk, and the maximum-bound logic pulses commit.
`timescale 1ns/1ps
`include "fsb_map.svh"

// Summary of operation
// R01: Hold 16-bit minimum frame period in cycles
// R02: Frame rate equals clock over period
// R03: Controller reads high byte before low
// R04: Controller writes low, high, then commits
// R05: Minimum period programmed 0x7E0E to 0xFFFF
// R06: Reads return last written staged value
// R07: New bounds wait for maximum-bound commit
// R08: Controller waits two frames after commit
// R09: Busy flag shows pending activation
// R10: Maximum period covers minimum plus shutter
// R11: Hold 16-bit maximum shutter in cycles
// R12: Shutter limit restricts reachable frame rates
// R13: Gain control off uses fixed shutter
// R14: Minimum low resets AC or 7E
// R15: Shutter resets 8C/00 low, 20 high
// R16: Revision shows firmware revision or zero
// R17: No bound writes during pending activation
// R18: Staged and active copies switch together
module fsb_bound_regs
    import fsb_pkg::*;
(
    input  wire logic      ref_clk,          // System clock, 100 MHz
    input  wire logic      rst_b,            // Synchronous reset, active low
    input  wire logic [6:0] reg_addr,        // Register offset of the access
    input  wire logic      reg_wr,           // Write strobe, one cycle
    input  wire logic      reg_rd,           // Read strobe, one cycle
    input  wire fsb_byte_t reg_wdata,        // Write data byte
    output fsb_byte_t      reg_rdata,        // Read data, one cycle later
    output logic           reg_rvalid,       // Read data valid pulse
    input  wire logic      max_bound_commit, // Maximum-bound pair written
    input  wire fsb_word_t max_period,       // Active maximum frame period
    input  wire logic      fw_loaded,        // Firmware download succeeded
    input  wire logic      fw_running,       // Chip runs downloaded firmware
    input  wire fsb_byte_t fw_revision_in,   // Revision of that firmware
    input  wire logic      agc_enable,       // Automatic gain control on
    input  wire fsb_word_t agc_shutter_req,  // Shutter asked by gain control
    input  wire fsb_word_t afr_period_req,   // Period asked by rate control
    output fsb_word_t      active_min_period,  // Active minimum period
    output fsb_word_t      active_max_shutter, // Active shutter limit
    output fsb_word_t      shutter_time,     // Shutter in use, cycles
    output fsb_word_t      frame_period,     // Frame period in use, cycles
    output logic           frame_tick,       // Pulse at each frame end
    output logic           busy,             // Activation still settling
    output fsb_byte_t      firmware_revision // Revision register value
);

    // Access decode
    logic      wr_min_low;     // Write to minimum period low byte
    logic      wr_min_high;    // Write to minimum period high byte
    logic      wr_shut_low;    // Write to shutter limit low byte
    logic      wr_shut_high;   // Write to shutter limit high byte
    fsb_word_t staged_min;     // Last written minimum period
    fsb_word_t staged_shutter; // Last written shutter limit
    fsb_word_t min_default;    // Minimum period default for this state
    fsb_word_t shut_default;   // Shutter limit default for this state
    logic      fw_loaded_q;    // Download flag one cycle ago
    logic      download_done;  // Download just finished
    fsb_byte_t next_rdata;     // Read data to register
    fsb_word_t next_shutter;   // Shutter for the coming cycle
    fsb_word_t period_floor;   // Shortest period allowed now
    fsb_word_t next_period;    // Period for the coming cycle
    fsb_word_t frame_cnt;      // Cycles elapsed in this frame
    fsb_word_t next_frame_cnt; // Frame counter after this cycle
    logic      frame_end;      // Last cycle of the current frame
    fsb_settle_t settle;       // Settling tracker state
    fsb_settle_t next_settle;  // Its next state
    fsb_byte_t next_revision;  // Revision register next value

    // Strobe decode; writes are accepted at any time, keeping clear of a
    // pending activation is the controller's duty
    // R17: writes not blocked
    always_comb begin
        wr_min_low   = reg_wr && (reg_addr == `FSB_OFS_MIN_PERIOD_LOW);
        wr_min_high  = reg_wr && (reg_addr == `FSB_OFS_MIN_PERIOD_HIGH);
        wr_shut_low  = reg_wr && (reg_addr == `FSB_OFS_MAX_SHUTTER_LOW);
        wr_shut_high = reg_wr && (reg_addr == `FSB_OFS_MAX_SHUTTER_HIGH);
    end

    // Defaults follow the download state, so a finished download reloads
    // the bounds just as a reset taken after download would
    // R14: minimum reset value
    // R15: shutter reset value
    always_comb begin
        if (fw_loaded) begin
            min_default  = {`FSB_MIN_HIGH_POST, `FSB_MIN_LOW_POST};
            shut_default = {`FSB_SHUT_HIGH_RST, `FSB_SHUT_LOW_POST};
        end else begin
            min_default  = {`FSB_MIN_HIGH_PRE, `FSB_MIN_LOW_PRE};
            shut_default = {`FSB_SHUT_HIGH_RST, `FSB_SHUT_LOW_PRE};
        end
        download_done = fw_loaded && !fw_loaded_q;
    end

    // R01: minimum period bound
    // R07: held until commit
    fsb_bound_pair u_min_period (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .load_defaults (download_done),
        .default_value (min_default),
        .wr_low        (wr_min_low),
        .wr_high       (wr_min_high),
        .wdata         (reg_wdata),
        .activate      (max_bound_commit),
        .staged        (staged_min),
        .active        (active_min_period)
    );

    // R11: shutter limit bound
    // R07: held until commit
    fsb_bound_pair u_max_shutter (
        .ref_clk       (ref_clk),
        .rst_b         (rst_b),
        .load_defaults (download_done),
        .default_value (shut_default),
        .wr_low        (wr_shut_low),
        .wr_high       (wr_shut_high),
        .wdata         (reg_wdata),
        .activate      (max_bound_commit),
        .staged        (staged_shutter),
        .active        (active_max_shutter)
    );

    // Read mux; bytes read independently, so either byte order works
    // R06: staged readback
    always_comb begin
        unique case (reg_addr)
            `FSB_OFS_MIN_PERIOD_LOW:   next_rdata = staged_min[`FSB_LOW_LSB +: 8];
            `FSB_OFS_MIN_PERIOD_HIGH:  next_rdata = staged_min[`FSB_HIGH_LSB +: 8];
            `FSB_OFS_MAX_SHUTTER_LOW:  next_rdata = staged_shutter[`FSB_LOW_LSB +: 8];
            `FSB_OFS_MAX_SHUTTER_HIGH: next_rdata = staged_shutter[`FSB_HIGH_LSB +: 8];
            `FSB_OFS_FW_REVISION:      next_rdata = firmware_revision;
            default:                   next_rdata = `FSB_READ_ZERO;
        endcase
        if (!reg_rd) begin
            next_rdata = reg_rdata;
        end
    end

    // Revision only when the chip really runs the downloaded image
    // R16: revision or zero
    always_comb begin
        next_revision = (fw_loaded && fw_running) ? fw_revision_in : `FSB_READ_ZERO;
    end

    // Shutter choice: fixed at the limit with gain control off, else the
    // request capped by the limit
    // R13: fixed shutter mode
    // R11: shutter capped
    always_comb begin
        if (!agc_enable) begin
            next_shutter = active_max_shutter;
        end else if (agc_shutter_req > active_max_shutter) begin
            next_shutter = active_max_shutter;
        end else begin
            next_shutter = agc_shutter_req;
        end
    end

    // Period choice: never below the minimum bound nor below the shutter
    // in use, never above the maximum bound; the maximum wins on conflict
    // R12: shutter limits rate
    // R01: period floor
    always_comb begin
        period_floor = (shutter_time > active_min_period) ? shutter_time
                                                          : active_min_period;
        next_period = (afr_period_req < period_floor) ? period_floor : afr_period_req;
        if (next_period > max_period) begin
            next_period = max_period;
        end
    end

    // Frame timer: one frame per period count, so rate is clock / period;
    // a zero period degenerates to one-cycle frames rather than wrapping
    // R02: period sets rate
    always_comb begin
        frame_end = ({1'b0, frame_cnt} + 17'h00001) >= {1'b0, frame_period};
        next_frame_cnt = frame_end ? 16'h0000 : frame_cnt + 16'h0001;
    end

    // Settling tracker: two frame ends after each commit, the first possibly ending a partial frame; a second
    // commit restarts the wait
    // R09: busy while settling
    // R08: two frame settle
    always_comb begin
        next_settle = settle;
        unique case (settle)
            FSB_IDLE:   next_settle = FSB_IDLE;
            FSB_FRAME1: next_settle = frame_end ? FSB_FRAME2 : FSB_FRAME1;
            FSB_FRAME2: next_settle = frame_end ? FSB_IDLE : FSB_FRAME2;
            default:    next_settle = FSB_IDLE;
        endcase
        if (max_bound_commit) begin
            next_settle = FSB_FRAME1;
        end
    end

    // All state and output registers outside the two bound pairs
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            // Taken as seen, so leaving reset never looks like a fresh
            // download that would wipe a write made at the first edge
            fw_loaded_q       <= fw_loaded;
            reg_rdata         <= `FSB_READ_ZERO;
            reg_rvalid        <= 1'b0;
            firmware_revision <= `FSB_READ_ZERO;
            shutter_time      <= 16'h0000;
            frame_period      <= 16'h0000;
            frame_cnt         <= 16'h0000;
            frame_tick        <= 1'b0;
            settle            <= FSB_IDLE;
            busy              <= 1'b0;
        end else begin
            fw_loaded_q       <= fw_loaded;
            reg_rdata         <= next_rdata;
            reg_rvalid        <= reg_rd;
            firmware_revision <= next_revision;
            shutter_time      <= next_shutter;
            frame_period      <= next_period;
            frame_cnt         <= next_frame_cnt;
            frame_tick        <= frame_end;
            settle            <= next_settle;
            busy              <= (next_settle != FSB_IDLE);
        end
    end

    // Checks on the bank's own outputs
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_commit;
        max_bound_commit && !download_done;
    endsequence

    sequence s_quiet_bounds;
        !max_bound_commit && !download_done;
    endsequence

    chk_commit_copies: assert property ( // R18
        s_commit |=> (active_min_period == $past(staged_min))
                  && (active_max_shutter == $past(staged_shutter)))
        else $error("active bounds differ from staged copies after commit");

    chk_hold_inactive: assert property ( // R07
        s_quiet_bounds |=> $stable(active_min_period) && $stable(active_max_shutter))
        else $error("active bound moved without a commit");

    chk_staged_readback: assert property ( // R06
        reg_rd && reg_addr == `FSB_OFS_MIN_PERIOD_LOW
            |=> reg_rvalid && reg_rdata == $past(staged_min[7:0]))
        else $error("minimum low byte readback mismatch");

    chk_fixed_shutter: assert property ( // R13
        !agc_enable |=> shutter_time == $past(active_max_shutter))
        else $error("shutter not fixed with gain control off");

    chk_shutter_cap: assert property ( // R11
        agc_enable |=> shutter_time <= $past(active_max_shutter))
        else $error("shutter exceeds its limit");

    chk_period_floor: assert property ( // R12
        max_period >= period_floor |=> frame_period >= $past(period_floor))
        else $error("frame period below floor");

    chk_busy_window: assert property ( // R09
        s_commit |=> ((settle == FSB_FRAME1) && busy) ##1 busy)
        else $error("busy not raised after commit");

    chk_revision_zero: assert property ( // R16
        !fw_running |=> firmware_revision == `FSB_READ_ZERO)
        else $error("revision shown without running firmware");

    chk_reset_defaults: assert property ( // R14
        disable iff (1'b0)
        (!rst_b && !fw_loaded) |=> staged_min[7:0] == `FSB_MIN_LOW_PRE
                                && staged_shutter == 16'h208C)
        else $error("pre-download reset values wrong");

    chk_frame_spacing: assert property ( // R02
        frame_tick && $stable(frame_period) && frame_period > 16'h0002
            |=> !frame_tick ##1 !frame_tick)
        else $error("frame ticks closer than the period");

endmodule

//--- fsb_map.svh
// Constant map of the frame and shutter bound registers: offsets,
// reset values and frame timing figures.
// Assumes a 100 MHz ref_clk and a 7-bit internal register address.
`ifndef FSB_MAP_SVH
`define FSB_MAP_SVH

// Register offsets on the internal register port
`define FSB_OFS_MIN_PERIOD_LOW   7'h1B
`define FSB_OFS_MIN_PERIOD_HIGH  7'h1C
`define FSB_OFS_MAX_SHUTTER_LOW  7'h1D
`define FSB_OFS_MAX_SHUTTER_HIGH 7'h1E
`define FSB_OFS_FW_REVISION      7'h1F

// Byte lanes of a 16-bit bound
`define FSB_LOW_LSB   0
`define FSB_HIGH_LSB  8

// Reset values before and after a firmware download
`define FSB_MIN_LOW_PRE    8'hAC
`define FSB_MIN_LOW_POST   8'h7E
`define FSB_MIN_HIGH_PRE   8'h0E
`define FSB_MIN_HIGH_POST  8'h0E
`define FSB_SHUT_LOW_PRE   8'h8C
`define FSB_SHUT_LOW_POST  8'h00
`define FSB_SHUT_HIGH_RST  8'h20

// Reads of unmapped offsets and of the revision without firmware
`define FSB_READ_ZERO      8'h00

// Settling time after activation, in frame ends, the first possibly partial
`define FSB_SETTLE_FRAMES  2

`endif

//--- fsb_pkg.sv
// Types shared by the frame and shutter bound register bank.
// Assumes nothing beyond a SystemVerilog compiler.
package fsb_pkg;

    // One register byte and one 16-bit bound
    typedef logic [7:0]  fsb_byte_t;
    typedef logic [15:0] fsb_word_t;

    // Settling tracker after activation, one bit changes per step except FSB_FRAME2 back to FSB_IDLE
    typedef enum logic [1:0] {
        FSB_IDLE   = 2'b00,
        FSB_FRAME1 = 2'b01,
        FSB_FRAME2 = 2'b11
    } fsb_settle_t;

endpackage

//--- fsb_bound_pair.sv
// One 16-bit bound held as a staged copy and an active copy.
// Assumes write strobes and activation are one-cycle pulses on ref_clk.
`timescale 1ns/1ps
module fsb_bound_pair
    import fsb_pkg::*;
(
    input  wire logic      ref_clk,       // System clock
    input  wire logic      rst_b,         // Synchronous reset, active low
    input  wire logic      load_defaults, // Reload both copies from defaults
    input  wire fsb_word_t default_value, // Value taken on reset or reload
    input  wire logic      wr_low,        // Write strobe for the low byte
    input  wire logic      wr_high,       // Write strobe for the high byte
    input  wire fsb_byte_t wdata,         // Byte being written
    input  wire logic      activate,      // Copy staged into active
    output fsb_word_t      staged,        // Last value written
    output fsb_word_t      active         // Value the control logic uses
);

    fsb_word_t next_staged;  // Staged copy after this cycle
    fsb_word_t next_active;  // Active copy after this cycle

    // Byte writes land in the staged copy only; activation copies it
    always_comb begin
        next_staged = staged;
        next_active = active;
        if (load_defaults) begin
            next_staged = default_value;
            next_active = default_value;
        end else begin
            if (wr_low) begin
                next_staged[`FSB_LOW_LSB +: 8] = wdata;
            end
            if (wr_high) begin
                next_staged[`FSB_HIGH_LSB +: 8] = wdata;
            end
            // R18: staged to active
            if (activate) begin
                next_active = staged;
            end
        end
    end

    // Registers only; reset uses the defaults chosen by the caller
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            staged <= default_value;
            active <= default_value;
        end else begin
            staged <= next_staged;
            active <= next_active;
        end
    end

endmodule

//--- fsb_ctrl_model.sv
// Microcontroller model on the internal bound register port.
// Assumes the bench calls its tasks; every change lands on a falling edge.
`timescale 1ns/1ps
module fsb_ctrl_model
    import fsb_pkg::*;
(
    input  wire logic      ref_clk,          // System clock
    output logic [6:0]     reg_addr,         // Register offset
    output logic           reg_wr,           // Write strobe
    output logic           reg_rd,           // Read strobe
    output fsb_byte_t      reg_wdata,        // Write byte
    input  wire fsb_byte_t reg_rdata,        // Read byte
    input  wire logic      reg_rvalid,       // Read data valid
    output logic           max_bound_commit, // Activation pulse
    input  wire logic      busy              // Activation settling
);
    // Quiet bus; released lines show inverted values, never a stale copy
    initial begin
        reg_addr = 7'h7F;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'hFF;
        max_bound_commit = 1'b0;
    end

    // One write strobe for one cycle
    task automatic wr(input logic [6:0] a, input fsb_byte_t d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge ref_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // One read strobe, data taken with the valid pulse (bounded wait)
    task automatic rd(input logic [6:0] a, output fsb_byte_t d);
        int i;
        @(negedge ref_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge ref_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        for (i = 0; i < 3 && reg_rvalid !== 1'b1; i++) begin
            @(negedge ref_clk);
        end
        d = reg_rdata;
    endtask

    // poll busy instead of a timer before touching bounds
    task automatic wait_idle();
        int i;
        for (i = 0; i < 90000 && busy !== 1'b0; i++) begin
            @(negedge ref_clk);
        end
    endtask

    task automatic put_bound(input logic [6:0] lo, input fsb_word_t v);
        wait_idle();
        wr(lo, v[7:0]);
        wr(lo + 7'h01, v[15:8]);
    endtask

    // high byte fetched before low byte
    task automatic get_bound(input logic [6:0] lo, output fsb_word_t v);
        rd(lo + 7'h01, v[15:8]);
        rd(lo, v[7:0]);
    endtask

    // maximum-bound pair written, so staged bounds go live
    task automatic commit();
        @(negedge ref_clk);
        max_bound_commit = 1'b1;
        @(negedge ref_clk);
        max_bound_commit = 1'b0;
    endtask
endmodule

//--- frame_shutter_bound_regs_tb_top.sv
// Self-checking bench for the frame and shutter bound registers.
// Assumes fsb_map.svh on the include path; a small integer model predicts.
`timescale 1ns/1ps
`include "fsb_map.svh"
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
module frame_shutter_bound_regs_tb_top
    import fsb_pkg::*;
;
    logic       ref_clk, rst_b, reg_wr, reg_rd, reg_rvalid, max_bound_commit;
    logic       fw_loaded, fw_running, agc_enable, frame_tick, busy;
    logic [6:0] reg_addr;
    fsb_byte_t  reg_wdata, reg_rdata, fw_revision_in, firmware_revision;
    fsb_word_t  max_period, agc_shutter_req, afr_period_req, shutter_time, frame_period;
    fsb_word_t  active_min_period, active_max_shutter;
    int         num_errors, samples_checked, seed, i, n;
    int         stg_min, stg_shut, exp_min, exp_shut; // Staged and active model
    int         ticks[$];                            // Cycle stamps of frame ends

    fsb_ctrl_model u_ctrl (.ref_clk(ref_clk), .reg_addr(reg_addr), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .max_bound_commit(max_bound_commit), .busy(busy));
    fsb_bound_regs dut (.ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .max_bound_commit(max_bound_commit),
        .max_period(max_period), .fw_loaded(fw_loaded), .fw_running(fw_running),
        .fw_revision_in(fw_revision_in), .agc_enable(agc_enable),
        .agc_shutter_req(agc_shutter_req), .afr_period_req(afr_period_req),
        .active_min_period(active_min_period), .active_max_shutter(active_max_shutter),
        .shutter_time(shutter_time), .frame_period(frame_period),
        .frame_tick(frame_tick), .busy(busy), .firmware_revision(firmware_revision));

    // 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Model of both copies after reset or reload
    task automatic set_defaults(input logic post);
        stg_min = post ? 'h0E7E : {`FSB_MIN_HIGH_PRE, 8'hAC};
        stg_shut = post ? 'h2000 : 'h208C;
        exp_min = stg_min;
        exp_shut = stg_shut;
    endtask

    task automatic do_reset(input logic post);
        rst_b = 1'b0;
        fw_loaded = post;
        repeat (2) @(negedge ref_clk);
        rst_b = 1'b1;
        set_defaults(post);
    endtask

    // Every register read back against the model, plus an unmapped offset
    task automatic check_regs();
        fsb_word_t v;
        fsb_byte_t b;
        int        r;
        r = (fw_loaded && fw_running) ? fw_revision_in : 0;
        u_ctrl.get_bound(`FSB_OFS_MIN_PERIOD_LOW, v);
        `CHK("min staged", stg_min[15:0], v)
        u_ctrl.get_bound(`FSB_OFS_MAX_SHUTTER_LOW, v);
        `CHK("shutter staged", stg_shut[15:0], v)
        u_ctrl.rd(`FSB_OFS_FW_REVISION, b);
        `CHK("revision", r[7:0], b)
        u_ctrl.rd(7'h20, b);
        `CHK("unmapped", 8'h00, b)
        `CHK("active min", exp_min[15:0], active_min_period)
        `CHK("active shutter", exp_shut[15:0], active_max_shutter)
    endtask

    // Shutter and period in use, shutter registered once and period up to twice from the inputs
    task automatic sel_check();
        int s, p;
        repeat (3) @(negedge ref_clk);
        s = (agc_enable && agc_shutter_req < exp_shut) ? agc_shutter_req : exp_shut;
        p = afr_period_req > exp_min ? afr_period_req : exp_min;
        p = s > p ? s : p;
        p = max_period < p ? max_period : p;
        `CHK("shutter in use", s[15:0], shutter_time)
        `CHK("period in use", p[15:0], frame_period)
    endtask

    initial begin
        seed = 32'he2df;
        num_errors = 0;
        samples_checked = 0;
        {rst_b, fw_loaded, fw_running, agc_enable} = 4'h0;
        fw_revision_in = 8'h00;
        {agc_shutter_req, afr_period_req} = 32'h0000_0000;
        max_period = 16'h1000;
        do_reset(1'b0);
        check_regs();
        // Download finishes: post defaults reload, revision shows
        fw_revision_in = 8'($random(seed));
        fw_running = 1'b1;
        @(negedge ref_clk);
        fw_loaded = 1'b1;
        set_defaults(1'b1);
        u_ctrl.wr(`FSB_OFS_FW_REVISION, ~fw_revision_in);
        check_regs();
        fw_running = 1'b0;
        check_regs();
        // staged values stay inside the allowed minimum range
        for (i = 0; i < 3; i++) begin
            stg_min = 'h7E0E + ($random(seed) & 'hFF);
            stg_shut = 'h100 + ($random(seed) & 'hFF);
            u_ctrl.put_bound(`FSB_OFS_MIN_PERIOD_LOW, 16'(stg_min));
            u_ctrl.put_bound(`FSB_OFS_MAX_SHUTTER_LOW, 16'(stg_shut));
            check_regs();
        end
        // Fixed and capped shutter, period clamps; short frames kept here
        for (i = 0; i < 8; i++) begin
            agc_enable = i[0];
            agc_shutter_req = 16'($random(seed));
            afr_period_req = 16'($random(seed));
            max_period = 16'h0800 + 16'($random(seed) & 'h17FF);
            sel_check();
        end
        // maximum period equals minimum plus shutter at the boundary
        agc_enable = 1'b0;
        afr_period_req = 16'h0000;
        max_period = 16'(stg_min + stg_shut);
        u_ctrl.commit();
        exp_min = stg_min;
        exp_shut = stg_shut;
        `CHK("active min", exp_min[15:0], active_min_period)
        `CHK("active shutter", exp_shut[15:0], active_max_shutter)
        `CHK("busy raised", 1'b1, busy)
        n = 0;
        do begin
            @(negedge ref_clk);
            n++;
            if (frame_tick === 1'b1) ticks.push_back(n);
        end while (busy === 1'b1 && n < 80000);
        `CHK("busy cleared", 1'b0, busy)
        `CHK("frames while busy", 2, ticks.size())
        `CHK("frame length", exp_min, ticks[1] - ticks[0])
        sel_check();
        // Second reset after a download
        fw_running = 1'b1;
        do_reset(1'b1);
        check_regs();
        report_and_stop();
    end

    // Watchdog sized for the two long frames after activation
    initial begin
        #(100000 * 10);
        num_errors++;
        report_and_stop();
    end
endmodule
